// [shared/srmc_pkg.sv]
package srmc_pkg;

    // ------------------------------------------------------------
    // Register map (software port, word index = byte address)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_WDOG_CTRL = 4'h0;  // watchdog_control_register
    localparam logic [3:0] ADDR_CONFIG_LOW = 4'h1; // config_word_low (read only image)
    localparam logic [3:0] ADDR_STATUS = 4'h2;     // regulator state, read only

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_STANDBY_SELECT = 7; // sleep_standby_select
    localparam int BIT_DEEP_ENABLE = 4;    // sleep_deep_regulator_enable
    localparam int BIT_CONFIG_OFF = 0;     // deep_regulator_config_off

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] WDOG_CTRL_RESET = 8'h00;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WAKE_HOLD_US = 250;
    // Least time, rounded up to whole cycles
    localparam int WAKE_HOLD_CYCLES = (WAKE_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRMC_REG_NORMAL,
        SRMC_REG_STANDBY,
        SRMC_REG_ULTRA,
        SRMC_REG_BYPASS,
        SRMC_REG_RESERVED
    } srmc_reg_mode_t;

    typedef enum logic [1:0] {
        SRMC_ST_RUN,
        SRMC_ST_SLEEP,
        SRMC_ST_WAKE_HOLD
    } srmc_state_t;

    // Software register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } srmc_bus_req_t;

    // Drive towards the regulator and reference circuits
    typedef struct packed {
        srmc_reg_mode_t mode;
        logic refs_on;
        logic ref_wake_allow;
    } srmc_reg_ctrl_t;

endpackage : srmc_pkg

// [rtl/srmc_wake_timer.sv]
`timescale 1ns/1ps
module srmc_wake_timer #(
    parameter int HOLD_CYCLES = srmc_pkg::WAKE_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic run;
        logic done;
    } srmc_timer_state_t;

    srmc_timer_state_t state;
    srmc_timer_state_t next_state;

    // ------------------------------------------------------------
    // Down counter, one-cycle done pulse at expiry
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        if (start) begin
            next_state.count = CW'(HOLD_CYCLES - 1);
            next_state.run = 1'b1;
        end else if (state.run) begin
            if (state.count == '0) begin
                next_state.run = 1'b0;
                next_state.done = 1'b1;
            end else begin
                next_state.count = state.count - CW'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign busy = state.run;
    assign done = state.done;
endmodule : srmc_wake_timer

// [rtl/srmc_sleep_ctrl.sv]
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Standby select 1 gives standby regulator in Sleep; 0 keeps normal operation.
// (R2) Standby sleep places the regulator in its low-current standby state.
// (R3) Ultra low-power set by config inhibit bit 0 and control bit 4.
// (R4) Inhibit 0 with deep enable 1 selects ultra low-power, standby bit ignored.
// (R5) Low-voltage part: inhibit 1 means bypass; inhibit 0 is reserved.
// (R6) Low-voltage parts should be configured with inhibit 1 for lowest current.
// (R7) References switch off during ultra low-power Sleep.
// (R8) Reference-based interrupts cannot wake while references are off.
// (R9) Brown-out or low-voltage detect enabled keeps references on.
// (R10) Wake from ultra low-power Sleep holds execution about 250 us.
// (R11) Any wake restores normal regulator and references before execution resumes.
module srmc_sleep_ctrl #(
    parameter int WAKE_HOLD_CYCLES = srmc_pkg::WAKE_HOLD_CYCLES,
    parameter bit LOW_VOLTAGE_PART = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire srmc_pkg::srmc_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic [7:0] config_word_low,
    input wire logic sleep_request,
    input wire logic wake_event,
    input wire logic wake_needs_ref,
    input wire logic brownout_reset_enable,
    input wire logic low_voltage_detect_enable,
    output srmc_pkg::srmc_reg_ctrl_t reg_ctrl,
    output logic asleep,
    output logic cpu_run
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic srmc_pkg::srmc_reg_mode_t decode_mode(
        input logic standby_sel,
        input logic deep_en,
        input logic cfg_off,
        input logic lv_part
    );
        if (lv_part) begin
            decode_mode = cfg_off ? srmc_pkg::SRMC_REG_BYPASS : srmc_pkg::SRMC_REG_RESERVED; // [R5]
        end else if (!cfg_off && deep_en) begin
            decode_mode = srmc_pkg::SRMC_REG_ULTRA; // [R3] [R4]
        end else if (standby_sel) begin
            decode_mode = srmc_pkg::SRMC_REG_STANDBY; // [R1] [R2]
        end else begin
            decode_mode = srmc_pkg::SRMC_REG_NORMAL; // [R1]
        end
    endfunction : decode_mode

    typedef struct packed {
        logic [7:0] wdog_ctrl;
        srmc_pkg::srmc_state_t fsm;
        srmc_pkg::srmc_reg_mode_t sleep_mode;
        logic [7:0] rdata;
        logic reserved_seen;
    } srmc_ctrl_state_t;

    srmc_ctrl_state_t state;
    srmc_ctrl_state_t next_state;

    logic timer_start;
    logic timer_busy;
    logic timer_done;
    srmc_pkg::srmc_reg_mode_t chosen_mode;
    logic refs_keep;
    logic refs_off;

    // Inhibit bit is read live; fuses do not change while running
    assign chosen_mode = decode_mode(state.wdog_ctrl[srmc_pkg::BIT_STANDBY_SELECT],
                                     state.wdog_ctrl[srmc_pkg::BIT_DEEP_ENABLE],
                                     config_word_low[srmc_pkg::BIT_CONFIG_OFF],
                                     LOW_VOLTAGE_PART);

    // References stay up when a supervisor needs them
    assign refs_keep = brownout_reset_enable || low_voltage_detect_enable; // [R9]
    assign refs_off = (state.fsm == srmc_pkg::SRMC_ST_SLEEP)
                      && (state.sleep_mode == srmc_pkg::SRMC_REG_ULTRA) && !refs_keep; // [R7]

    // Only the ultra mode pays the wake hold
    assign timer_start = (state.fsm == srmc_pkg::SRMC_ST_SLEEP) && wake_event
                         && !(refs_off && wake_needs_ref)
                         && (state.sleep_mode == srmc_pkg::SRMC_REG_ULTRA); // [R10]

    // ------------------------------------------------------------
    // Next state: register port and sleep sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.rdata = 8'h00;
        if (bus_req.wr && bus_req.addr == srmc_pkg::ADDR_WDOG_CTRL) begin
            next_state.wdog_ctrl = bus_req.wdata;
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                srmc_pkg::ADDR_WDOG_CTRL: next_state.rdata = state.wdog_ctrl;
                srmc_pkg::ADDR_CONFIG_LOW: next_state.rdata = config_word_low;
                srmc_pkg::ADDR_STATUS: next_state.rdata = {state.reserved_seen, refs_off,
                                                           timer_busy, 5'(state.sleep_mode)};
                default: next_state.rdata = 8'h00;
            endcase
        end
        unique case (state.fsm)
            srmc_pkg::SRMC_ST_RUN: begin
                if (sleep_request) begin
                    next_state.fsm = srmc_pkg::SRMC_ST_SLEEP;
                    next_state.sleep_mode = chosen_mode;
                    // Reserved combination: stay in normal regulation, flag it
                    if (chosen_mode == srmc_pkg::SRMC_REG_RESERVED) begin
                        next_state.sleep_mode = srmc_pkg::SRMC_REG_NORMAL; // [R5]
                        next_state.reserved_seen = 1'b1;
                    end
                end
            end
            srmc_pkg::SRMC_ST_SLEEP: begin
                // Reference-based sources are deaf while references are off
                if (wake_event && !(refs_off && wake_needs_ref)) begin // [R8]
                    next_state.sleep_mode = srmc_pkg::SRMC_REG_NORMAL; // [R11]
                    next_state.fsm = timer_start ? srmc_pkg::SRMC_ST_WAKE_HOLD
                                                 : srmc_pkg::SRMC_ST_RUN;
                end
            end
            srmc_pkg::SRMC_ST_WAKE_HOLD: begin
                if (timer_done) begin
                    next_state.fsm = srmc_pkg::SRMC_ST_RUN; // [R10]
                end
            end
            default: next_state.fsm = srmc_pkg::SRMC_ST_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state.wdog_ctrl <= srmc_pkg::WDOG_CTRL_RESET;
            state.fsm <= srmc_pkg::SRMC_ST_RUN;
            state.sleep_mode <= srmc_pkg::SRMC_REG_NORMAL;
            state.rdata <= 8'h00;
            state.reserved_seen <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Wake hold timer
    // ------------------------------------------------------------
    srmc_wake_timer #(
        .HOLD_CYCLES(WAKE_HOLD_CYCLES)
    ) u_wake_timer (
        .clk(clk),
        .reset(reset),
        .start(timer_start),
        .busy(timer_busy),
        .done(timer_done)
    );

    // Outputs: normal regulator and references already back during hold
    always_comb begin
        reg_ctrl.mode = state.sleep_mode; // [R11]
        reg_ctrl.refs_on = !refs_off; // [R7] [R11]
        reg_ctrl.ref_wake_allow = !refs_off; // [R8]
    end
    assign rdata = state.rdata;
    assign asleep = (state.fsm == srmc_pkg::SRMC_ST_SLEEP);
    assign cpu_run = (state.fsm == srmc_pkg::SRMC_ST_RUN);

endmodule : srmc_sleep_ctrl

// [tb/srmc_sleep_ctrl_properties.sv]
`timescale 1ns/1ps
module srmc_sleep_ctrl_properties #(
    parameter int WAKE_HOLD_CYCLES = srmc_pkg::WAKE_HOLD_CYCLES,
    parameter bit LOW_VOLTAGE_PART = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire srmc_pkg::srmc_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic [7:0] config_word_low,
    input wire logic sleep_request,
    input wire logic wake_event,
    input wire logic wake_needs_ref,
    input wire logic brownout_reset_enable,
    input wire logic low_voltage_detect_enable,
    input wire srmc_pkg::srmc_reg_ctrl_t reg_ctrl,
    input wire logic asleep,
    input wire logic cpu_run
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [7:0] wd;
    logic [15:0] hold;
    logic ult;
    logic ok_wake;
    srmc_pkg::srmc_reg_mode_t want;

    function automatic srmc_pkg::srmc_reg_mode_t dec(input logic [7:0] w, input logic c);
        if (LOW_VOLTAGE_PART) return c ? srmc_pkg::SRMC_REG_BYPASS : srmc_pkg::SRMC_REG_NORMAL;
        if (!c && w[4]) return srmc_pkg::SRMC_REG_ULTRA;
        return w[7] ? srmc_pkg::SRMC_REG_STANDBY : srmc_pkg::SRMC_REG_NORMAL;
    endfunction : dec

    // Shadow of the control register; the hold counter measures the stall after wake
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wd <= 8'h00;
            hold <= 16'h0000;
        end else begin
            if (bus_req.wr && bus_req.addr == srmc_pkg::ADDR_WDOG_CTRL) begin
                wd <= bus_req.wdata;
            end
            hold <= (!cpu_run && !asleep) ? hold + 16'h0001 : 16'h0000;
        end
    end

    // Decoded expectation, sampled one cycle back at sleep entry
    assign want = dec(wd, config_word_low[0]);
    assign ult = reg_ctrl.mode == srmc_pkg::SRMC_REG_ULTRA;
    assign ok_wake = asleep && wake_event && (reg_ctrl.refs_on || !wake_needs_ref);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_sleep_take: assert property (sleep_request && cpu_run |=> asleep)
        else $error("Sleep request not taken");
    chk_sleep_mode: assert property ($rose(asleep) |-> reg_ctrl.mode == $past(want))
        else $error("Wrong regulator mode in sleep");
    chk_refs_ultra: assert property (asleep && ult |-> reg_ctrl.refs_on == (brownout_reset_enable || low_voltage_detect_enable))
        else $error("Reference state wrong in deep sleep");
    chk_ref_wake_gate: assert property (!reg_ctrl.refs_on |-> !reg_ctrl.ref_wake_allow)
        else $error("Reference wake allowed with references off");
    chk_wake_refused: assert property (asleep && !reg_ctrl.refs_on && wake_event && wake_needs_ref |=> asleep)
        else $error("Reference wake accepted while references off");
    chk_wake_restore: assert property (ok_wake |=> !asleep && reg_ctrl.refs_on && reg_ctrl.mode == srmc_pkg::SRMC_REG_NORMAL)
        else $error("Regulator not restored on wake");
    chk_fast_wake: assert property (ok_wake && !ult |=> cpu_run)
        else $error("Execution late after shallow wake");
    chk_hold_length: assert property ($rose(cpu_run) && !$past(asleep) |-> hold == WAKE_HOLD_CYCLES + 1)
        else $error("Wake hold length wrong");
    chk_hold_bound: assert property (hold <= WAKE_HOLD_CYCLES + 1)
        else $error("Wake hold overran");
    chk_ctrl_readback: assert property ($past(bus_req.rd && bus_req.addr == srmc_pkg::ADDR_WDOG_CTRL) |-> rdata[7] == $past(wd[7]) && rdata[4] == $past(wd[4]))
        else $error("Control bits read back wrong");

    // Main scenarios reached
    cover property ($rose(asleep) && ult);
    cover property (asleep && !reg_ctrl.refs_on && wake_event && wake_needs_ref);
    cover property ($rose(cpu_run) && !$past(asleep));
endmodule : srmc_sleep_ctrl_properties

bind srmc_sleep_ctrl srmc_sleep_ctrl_properties #(.WAKE_HOLD_CYCLES(WAKE_HOLD_CYCLES), .LOW_VOLTAGE_PART(LOW_VOLTAGE_PART)) u_props (
    .clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata), .config_word_low(config_word_low),
    .sleep_request(sleep_request), .wake_event(wake_event), .wake_needs_ref(wake_needs_ref),
    .brownout_reset_enable(brownout_reset_enable), .low_voltage_detect_enable(low_voltage_detect_enable),
    .reg_ctrl(reg_ctrl), .asleep(asleep), .cpu_run(cpu_run));

// [tb/srmc_sleep_ctrl_tb_top.sv]
`timescale 1ns/1ps
module srmc_sleep_ctrl_tb_top;
    // ----------------------------------------
    // Signals; short hold keeps the run brief
    // ----------------------------------------
    localparam int HOLD = 8;
    localparam srmc_pkg::srmc_reg_mode_t NRM = srmc_pkg::SRMC_REG_NORMAL;
    localparam srmc_pkg::srmc_reg_mode_t SBY = srmc_pkg::SRMC_REG_STANDBY;
    localparam srmc_pkg::srmc_reg_mode_t ULT = srmc_pkg::SRMC_REG_ULTRA;
    logic clk = 1'b0;
    logic reset = 1'b1;
    srmc_pkg::srmc_bus_req_t bus_req = '0;
    logic [7:0] cfg = 8'h00;
    logic sleep_request = 1'b0;
    logic wake_event = 1'b0;
    logic wake_needs_ref = 1'b0;
    logic [1:0] det = 2'b00;
    logic [7:0] rdata;
    logic asleep;
    logic cpu_run;
    srmc_pkg::srmc_reg_ctrl_t reg_ctrl;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    srmc_sleep_ctrl #(.WAKE_HOLD_CYCLES(HOLD), .LOW_VOLTAGE_PART(1'b0)) u_dut (
        .clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata), .config_word_low(cfg),
        .sleep_request(sleep_request), .wake_event(wake_event), .wake_needs_ref(wake_needs_ref),
        .brownout_reset_enable(det[1]), .low_voltage_detect_enable(det[0]),
        .reg_ctrl(reg_ctrl), .asleep(asleep), .cpu_run(cpu_run));

    // Clock and a hang guard
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            end_sim();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus_req.wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus_req.rd <= 1'b0;
        #1 cmp(rdata & m, e);
    endtask : rd

    task automatic wake(input logic nr);
        @(posedge clk);
        wake_event <= 1'b1;
        wake_needs_ref <= nr;
        @(posedge clk) wake_event <= 1'b0;
        #1;
    endtask : wake

    task automatic sleep_wake(input logic [7:0] w, input logic c, input logic [1:0] d,
                              input srmc_pkg::srmc_reg_mode_t m);
        logic refs;
        int n;
        refs = (m != ULT) || (d != 2'b00);
        wr(srmc_pkg::ADDR_WDOG_CTRL, w);
        rd(srmc_pkg::ADDR_WDOG_CTRL, 8'h90, w & 8'h90);
        // Fuse image and supervisors change on the edge that raises the request
        @(posedge clk);
        cfg <= {7'h00, c};
        det <= d;
        sleep_request <= 1'b1;
        @(posedge clk) sleep_request <= 1'b0;
        #1 cmp({7'h00, asleep}, 8'h01);
        cmp({5'h00, reg_ctrl.mode}, {5'h00, m});
        cmp({7'h00, reg_ctrl.refs_on}, {7'h00, refs});
        rd(srmc_pkg::ADDR_STATUS, 8'h7f, {1'b0, !refs, 1'b0, 5'(m)});
        if (!refs) begin
            wake(1'b1);
            cmp({7'h00, asleep}, 8'h01);
        end
        wake(1'b0);
        cmp({4'h0, reg_ctrl.refs_on, reg_ctrl.mode}, {4'h1, NRM});
        n = 1;
        while (cpu_run !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        cmp(n[7:0], 8'(m == ULT ? HOLD + 2 : 1));
    endtask : sleep_wake

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        cfg <= 8'h5b;
        rd(srmc_pkg::ADDR_WDOG_CTRL, 8'hff, srmc_pkg::WDOG_CTRL_RESET);
        wr(srmc_pkg::ADDR_CONFIG_LOW, 8'h00);
        rd(srmc_pkg::ADDR_CONFIG_LOW, 8'hff, 8'h5b);
        rd(4'hf, 8'hff, 8'h00);
        sleep_wake(8'h00, 1'b1, 2'b00, NRM);
        sleep_wake(8'h80, 1'b1, 2'b00, SBY);
        sleep_wake(8'h80, 1'b0, 2'b00, SBY);
        sleep_wake(8'h90, 1'b0, 2'b00, ULT);
        sleep_wake(8'h10, 1'b0, 2'b10, ULT);
        sleep_wake(8'h10, 1'b0, 2'b01, ULT);
        sleep_wake(8'h10, 1'b1, 2'b00, NRM);
        end_sim();
    end
endmodule : srmc_sleep_ctrl_tb_top
